// ===== hw/psl_link_top.sv
// How it works
// - Each rising source clock edge captures all 21 parallel input bits.
// - Transmitter drives three serial lanes; receiver accepts three matching lanes.
// - Four pairs total: three data lanes plus one forwarded clock.
// - Receiver presents 21 data bits and a clock whose rising edge strobes them.
// - Transmitter powerdown low puts all lane and clock outputs in high impedance.
// - Receiver powerdown low forces every receiver output low.
// - Floating data lanes read high; with clock running, outputs go all high.
// - Clock and data floating: data outputs hold the last valid word.
// - Floating forwarded clock drives the recovered clock low.
// - Each lane carries seven bit slots per forwarded clock period.
// - Outputs start toggling only after a 10 ms lock interval.
// - Forwarded clock stopping stops the output clock and holds data.
`timescale 1ns/1ps
`default_nettype none
module psl_link_top #(
  parameter int unsigned LOCK_CYCLES = psl_pkg::LOCK_CYCLES
) (
  // System clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Transmitter parallel side.
  input  wire logic        sourceClockIn,
  input  wire logic [20:0] parDataIn,
  input  wire logic        txPowerdownN,
  output logic             txDropped,
  // Transmitter serial side.
  output logic [2:0]       serialLaneOut,
  output logic             serialLaneOeN,
  output logic             forwardedClockOut,
  output logic             forwardedClockOeN,
  // Receiver serial side.
  input  wire logic [2:0]  serialLaneIn,
  input  wire logic        forwardedClockIn,
  input  wire logic        rxPowerdownN,
  // Receiver parallel side.
  output logic [20:0]      parDataOut,
  output logic             recoveredClockOut
);
  localparam int unsigned W = psl_pkg::WORD_BITS;
  localparam int unsigned CB = psl_pkg::LOCK_CNT_BITS;

  // Position of a lane bit inside the parallel word.
  function automatic int unsigned bitIndex(input int unsigned lane, input logic [3:0] cnt);
    bitIndex = lane * psl_pkg::SLOTS + int'(cnt) / psl_pkg::BIT_CYCLES;
  endfunction

  // Slot number of a cycle count within a frame.
  function automatic logic [2:0] slotOf(input logic [3:0] cnt);
    slotOf = 3'(int'(cnt) / psl_pkg::BIT_CYCLES);
  endfunction

  logic [1:0]   rstPipe_reg;
  wire          rstSyncN;
  logic [27:0]  pinMeta_reg;
  logic [27:0]  pinStable_reg;
  logic         srcPrev_reg;
  logic         fwdPrev_reg;
  logic [CB-1:0] txLockCnt_reg;
  logic [CB-1:0] rxLockCnt_reg;
  psl_pkg::psl_tx_state_t txState_reg;
  logic [3:0]   txCnt_reg;
  logic [W-1:0] txWord_reg;
  logic [3:0]   rxCnt_reg;
  logic         rxBusy_reg;
  logic [W-1:0] rxWord_reg;
  logic [W-1:0] rxWordNext;
  logic [6:0]   rxIdleCnt_reg;
  logic [2:0]   laneBits;

  // Reset is applied at once and released through two flops.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rstPipe_reg <= 2'h0;
    end else begin
      rstPipe_reg <= {rstPipe_reg[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipe_reg[1];

  // Every pin passes two flops; only the stable copy is read by logic.
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pinMeta_reg   <= 28'h0;
      pinStable_reg <= 28'h0;
      srcPrev_reg   <= 1'b0;
      fwdPrev_reg   <= 1'b0;
    end else begin
      pinMeta_reg   <= {serialLaneIn, forwardedClockIn, rxPowerdownN,
                        txPowerdownN, sourceClockIn, parDataIn};
      pinStable_reg <= pinMeta_reg;
      srcPrev_reg   <= pinStable_reg[21];
      fwdPrev_reg   <= pinStable_reg[24];
    end
  end

  wire [W-1:0] txDataSync  = pinStable_reg[20:0];
  wire         srcClkSync  = pinStable_reg[21];
  wire         txPowered   = pinStable_reg[22];
  wire         rxPowered   = pinStable_reg[23];
  wire         fwdClkSync  = pinStable_reg[24];
  wire [2:0]   rxLaneSync  = pinStable_reg[27:25];
  wire         srcRise     = srcClkSync && !srcPrev_reg;
  wire         fwdRise     = fwdClkSync && !fwdPrev_reg;
  wire         fwdChange   = fwdClkSync != fwdPrev_reg;
  wire         txLocked    = txLockCnt_reg == CB'(LOCK_CYCLES);
  wire         rxLocked    = rxLockCnt_reg == CB'(LOCK_CYCLES);
  wire         rxStalled   = rxIdleCnt_reg == psl_pkg::STALL_CYCLES;

  // Lock counters restart whenever powerdown is asserted.
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      txLockCnt_reg <= '0;
      rxLockCnt_reg <= '0;
    end else begin
      txLockCnt_reg <= !txPowered ? '0 : txLocked ? txLockCnt_reg : txLockCnt_reg + 1'b1;
      rxLockCnt_reg <= !rxPowered ? '0 : rxLocked ? rxLockCnt_reg : rxLockCnt_reg + 1'b1;
    end
  end

  // Two-entry buffer between capture and serializer; a serializer stall loses a word only when both entries are full.
  wire          bufInValid = srcRise && txPowered && txLocked;
  wire          bufInReady;
  wire          bufOutValid;
  wire [W-1:0]  bufOutData;
  wire          txSending  = txState_reg == psl_pkg::TX_SEND;
  wire          txLast     = txSending && (txCnt_reg == psl_pkg::FRAME_CYCLES - 4'h1);
  wire          bufOutReady = txLocked && ((txState_reg == psl_pkg::TX_IDLE) || txLast);
  wire          txPop      = bufOutReady && bufOutValid;

  psl_buffer #(
    .WIDTH (W),
    .DEPTH (2)
  ) u_txBuffer (
    .clk_sys  (clk_sys),
    .rstSyncN (rstSyncN),
    .flush    (!txPowered),
    .inValid  (bufInValid),
    .inReady  (bufInReady),
    .inData   (txDataSync),
    .outValid (bufOutValid),
    .outReady (bufOutReady),
    .outData  (bufOutData)
  );

  // Serializer: frames follow back to back while words are waiting.
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      txState_reg <= psl_pkg::TX_IDLE;
      txCnt_reg   <= 4'h0;
      txWord_reg  <= '0;
    end else if (txPop) begin
      txState_reg <= psl_pkg::TX_SEND;
      txCnt_reg   <= 4'h0;
      txWord_reg  <= bufOutData;
    end else if (txLast || !txLocked) begin
      txState_reg <= psl_pkg::TX_IDLE;
      txCnt_reg   <= 4'h0;
    end else if (txSending) begin
      txCnt_reg   <= txCnt_reg + 4'h1;
    end
  end

  // Lane bits of the current slot; lane l slot s carries word bit l*7+s.
  always_comb begin
    laneBits = 3'h0;
    for (int unsigned l = 0; l < psl_pkg::LANES; l++) begin
      laneBits[l] = txWord_reg[bitIndex(l, txCnt_reg)];
    end
  end

  // Serial outputs are registered; powerdown releases the pins to high impedance.
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      serialLaneOut     <= 3'h0;
      forwardedClockOut <= 1'b0;
      serialLaneOeN     <= 1'b1;
      forwardedClockOeN <= 1'b1;
      txDropped         <= 1'b0;
    end else begin
      serialLaneOut     <= (txSending && txPowered) ? laneBits : 3'h0;
      forwardedClockOut <= txSending && txPowered
                           && (slotOf(txCnt_reg) < psl_pkg::CLK_HIGH_SLOTS);
      serialLaneOeN     <= !txPowered;
      forwardedClockOeN <= !txPowered;
      txDropped         <= bufInValid && !bufInReady;
    end
  end

  // Receiver frame timer: restarts on each forwarded clock rise, samples mid-bit.
  wire sampleNow = rxBusy_reg
                   && ((int'(rxCnt_reg) % psl_pkg::BIT_CYCLES) == int'(psl_pkg::SAMPLE_PHASE));
  wire rxDone    = sampleNow && (slotOf(rxCnt_reg) == 3'(psl_pkg::SLOTS - 1));
  // A real frame has its clock low in the last slot; a floating clock stuck high
  // would otherwise publish an all-high word instead of holding the last one.
  wire rxPublish = rxDone && rxLocked && !fwdClkSync;

  always_comb begin
    rxWordNext = rxWord_reg;
    if (sampleNow) begin
      for (int unsigned l = 0; l < psl_pkg::LANES; l++) begin
        rxWordNext[bitIndex(l, rxCnt_reg)] = rxLaneSync[l];
      end
    end
  end

  // Frame timer and idle watchdog of the forwarded clock.
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      rxCnt_reg     <= 4'h0;
      rxBusy_reg    <= 1'b0;
      rxWord_reg    <= '0;
      rxIdleCnt_reg <= 7'h0;
    end else begin
      rxWord_reg    <= rxWordNext;
      rxIdleCnt_reg <= fwdChange ? 7'h0 : rxStalled ? rxIdleCnt_reg : rxIdleCnt_reg + 7'h1;
      if (fwdRise) begin
        rxCnt_reg  <= 4'h1;
        rxBusy_reg <= 1'b1;
      end else if (rxDone) begin
        rxBusy_reg <= 1'b0;
      end else if (rxBusy_reg) begin
        rxCnt_reg  <= rxCnt_reg + 4'h1;
      end
    end
  end

  // A word is published while the forwarded clock is low, so the next rise strobes it.
  // Without clock edges nothing is published and the last word stays on the pins.
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      parDataOut        <= '0;
      recoveredClockOut <= 1'b0;
    end else begin
      if (!rxPowered) begin
        parDataOut <= '0;
      end else if (rxPublish) begin
        parDataOut <= rxWordNext;
      end
      recoveredClockOut <= rxPowered && rxLocked && !rxStalled && fwdClkSync;
    end
  end

  // Checks.
  AST_TX_PD_HIGHZ: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
    !txPowered |=> serialLaneOeN && forwardedClockOeN && serialLaneOut == 3'h0)
    else $error("transmitter outputs not released in powerdown");
  AST_RX_PD_LOW: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
    !rxPowered |=> parDataOut == '0 && !recoveredClockOut)
    else $error("receiver outputs not low in powerdown");
  AST_TX_LOCK_QUIET: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
    !txLocked |=> !forwardedClockOut ##1 !forwardedClockOut)
    else $error("forwarded clock toggled before lock");
  AST_RX_LOCK_QUIET: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
    !rxLocked |=> !recoveredClockOut)
    else $error("recovered clock toggled before lock");
  AST_RX_STALL_CLK: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
    rxStalled |=> !recoveredClockOut)
    else $error("recovered clock not low with stopped input clock");
  AST_RX_STALL_HOLD: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
    rxStalled && rxPowered && !rxBusy_reg |=> $stable(parDataOut))
    else $error("data changed with stopped input clock");
  AST_FRAME_SHAPE: assert property (@(posedge clk_sys) disable iff (!rstSyncN || !txPowered)
    txSending && txCnt_reg == 4'h0 |=> forwardedClockOut[*8] ##1 !forwardedClockOut)
    else $error("forwarded clock frame shape wrong");
  AST_TX_CAPTURE: assert property (@(posedge clk_sys) disable iff (!rstSyncN || !txPowered)
    bufInValid && bufInReady |=> bufOutValid)
    else $error("captured word not buffered");
  AST_RX_PUBLISH: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
    rxPublish && rxPowered |=> parDataOut == $past(rxWordNext))
    else $error("received word not published");
  AST_LANE_MAP: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
    txSending && txPowered |=> serialLaneOut == $past(laneBits))
    else $error("lane bit mapping wrong");

  COV_FRAME: cover property (@(posedge clk_sys) txLast && txPop);
  COV_PUBLISH: cover property (@(posedge clk_sys) rxPublish && rxPowered);
  COV_STALL: cover property (@(posedge clk_sys) $rose(rxStalled));
  COV_TX_PD: cover property (@(posedge clk_sys) txSending ##1 !txPowered);
endmodule
`default_nettype wire

// ===== hw/psl_pkg.sv
package psl_pkg;
  // Link geometry.
  localparam int unsigned WORD_BITS = 21;
  localparam int unsigned LANES = 3;
  localparam int unsigned SLOTS = 7;
  // Forwarded clock stays high for this many leading slots of each frame.
  localparam logic [2:0] CLK_HIGH_SLOTS = 3'h4;
  // System clock and bit timing.
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned BIT_CYCLES = 2;
  localparam logic [3:0] FRAME_CYCLES = 4'(SLOTS * BIT_CYCLES);
  localparam logic [3:0] SAMPLE_PHASE = 4'(BIT_CYCLES / 2);
  // Lock interval after powerdown release.
  localparam int unsigned LOCK_TIME_MS = 10;
  localparam int unsigned LOCK_CYCLES = LOCK_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned LOCK_CNT_BITS = 22;
  // Forwarded clock counts as stopped after this many cycles without a change.
  localparam logic [6:0] STALL_CYCLES = 7'h40;
  // Serializer states.
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } psl_tx_state_t;
endpackage

// ===== hw/psl_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module psl_buffer #(
  parameter int unsigned WIDTH = 21,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset.
  input  wire logic             clk_sys,
  input  wire logic             rstSyncN,
  input  wire logic             flush,
  // Fill side.
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side.
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wrPtr_reg;
  logic [PW-1:0]    rdPtr_reg;
  logic [PW:0]      count_reg;
  wire              doWrite;
  wire              doRead;

  // Full and empty come from the occupancy count, so both are exact.
  assign inReady  = (count_reg != (PW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData  = mem_reg[rdPtr_reg];
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;

  // Storage is written only on an accepted word; it needs no reset.
  always_ff @(posedge clk_sys) begin
    if (doWrite) begin
      mem_reg[wrPtr_reg] <= inData;
    end
  end

  // Pointers wrap at the depth; flush drops any stored words.
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else if (flush) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_reg <= (wrPtr_reg == PW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (doRead) begin
        rdPtr_reg <= (rdPtr_reg == PW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + (PW+1)'(doWrite) - (PW+1)'(doRead);
    end
  end
endmodule
`default_nettype wire

// ===== test/psl_cable_model.sv
`timescale 1ns/1ps
`default_nettype none
module psl_cable_model (
  // Transmitter end of the four pairs.
  input  wire logic [2:0] laneTx,
  input  wire logic       laneOeN,
  input  wire logic       clkTx,
  input  wire logic       clkOeN,
  // Bench control that opens the three data pairs only.
  input  wire logic       cutData,
  // Receiver end of the four pairs.
  output logic [2:0]      laneRx,
  output logic            clkRx
);
  // An undriven pair reads high through the receiver's failsafe bias, never as a stale level.
  assign laneRx = (laneOeN !== 1'b0 || cutData) ? 3'h7 : laneTx;
  assign clkRx  = (clkOeN !== 1'b0) ? 1'b1 : clkTx;
endmodule
`default_nettype wire

// ===== test/psl_link_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK_EQ(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("mismatch at %0t ns: %s", $time, msg); end end
module psl_link_top_tb_top;
  // Stimulus, observed pins and bookkeeping.
  logic        clk_sys, rstn, sourceClockIn, txPowerdownN, rxPowerdownN, cutData, sawDrop;
  logic [20:0] parDataIn, parDataOut;
  logic        txDropped, serialLaneOeN, forwardedClockOut, forwardedClockOeN;
  logic [2:0]  serialLaneOut, serialLaneIn;
  logic        forwardedClockIn, recoveredClockOut;
  logic [20:0] strobes[$], seen[$];
  int          n_fail, n_checks;
  localparam logic [20:0] WORDS [5] = '{21'h155555, 21'h0aaaaa, 21'h1fffff, 21'h000001, 21'h100000};

  // Short lock count keeps the run brief.
  psl_link_top #(.LOCK_CYCLES(16)) dut (.clk_sys, .rstn, .sourceClockIn, .parDataIn,
    .txPowerdownN, .txDropped, .serialLaneOut, .serialLaneOeN, .forwardedClockOut,
    .forwardedClockOeN, .serialLaneIn, .forwardedClockIn, .rxPowerdownN, .parDataOut,
    .recoveredClockOut);
  psl_cable_model cable (.laneTx(serialLaneOut), .laneOeN(serialLaneOeN),
    .clkTx(forwardedClockOut), .clkOeN(forwardedClockOeN), .cutData,
    .laneRx(serialLaneIn), .clkRx(forwardedClockIn));

  // System clock at 250 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Record what downstream logic would strobe, every word change, and any drop pulse.
  always @(posedge recoveredClockOut) strobes.push_back(parDataOut);
  always @(parDataOut) seen.push_back(parDataOut);
  always @(posedge clk_sys) if (txDropped === 1'b1) sawDrop <= 1'b1;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One source clock period of 2*h cycles, started right after an edge; data
  // changes with the fall, so it stays put across the rise.
  task automatic sendWord(input logic [20:0] w, input int h);
    parDataIn <= w;
    repeat (h) @(posedge clk_sys);
    sourceClockIn <= 1'b1;
    repeat (h) @(posedge clk_sys);
    sourceClockIn <= 1'b0;
  endtask

  // Reads one frame off the wire mid-slot and rebuilds the word from the lane map.
  task automatic wireCheck(input logic [20:0] w);
    logic [20:0] got;
    int k;
    k = 0;
    got = '0;
    @(negedge clk_sys);
    while (forwardedClockOut !== 1'b1 && k < 100) begin
      @(negedge clk_sys);
      k++;
    end
    for (int s = 0; s < 7; s++) begin
      for (int l = 0; l < 3; l++) got[l*7+s] = serialLaneOut[l];
      `CHECK_EQ(forwardedClockOut, 1'(s < 4), "forwarded clock shape")
      `CHECK_EQ({serialLaneOeN, forwardedClockOeN}, 2'b00, "pairs not driven")
      repeat (2) @(negedge clk_sys);
    end
    `CHECK_EQ(got, w, "lane bit order")
    `CHECK_EQ(got, w, "lane slot map")
  endtask

  task automatic t_wire;
    fork
      sendWord(21'h1a5c3e, 10);
      wireCheck(21'h1a5c3e);
    join
    cyc(30);
    `CHECK_EQ(parDataOut, 21'h1a5c3e, "word after one frame")
    $display("test wire done");
  endtask

  // Spaced frames: each recovered clock rise strobes the word of the frame before.
  task automatic t_burst;
    logic [20:0] prev;
    prev = parDataOut;
    strobes.delete();
    for (int i = 0; i < 5; i++) sendWord(WORDS[i], 10);
    cyc(40);
    `CHECK_EQ(strobes.size(), 5, "strobe count")
    `CHECK_EQ(strobes[0], prev, "first strobe")
    for (int i = 0; i < 4; i++) `CHECK_EQ(strobes[i+1], WORDS[i], "strobed word")
    `CHECK_EQ(parDataOut, WORDS[4], "last burst word")
    $display("test burst done");
  endtask

  task automatic t_failsafe;
    @(posedge clk_sys);
    cutData <= 1'b1;
    sendWord(21'h000000, 10);
    cyc(30);
    `CHECK_EQ(parDataOut, 21'h1fffff, "floating lanes not high")
    cutData <= 1'b0;
    $display("test failsafe done");
  endtask

  // Transmitter off: pairs float, the forwarded clock stalls and the word is held.
  task automatic t_txpd;
    logic [20:0] last;
    sendWord(21'h1e2d3c, 10);
    cyc(30);
    last = parDataOut;
    `CHECK_EQ(last, 21'h1e2d3c, "word before tx powerdown")
    @(posedge clk_sys);
    txPowerdownN <= 1'b0;
    cyc(4);
    `CHECK_EQ({serialLaneOeN, forwardedClockOeN}, 2'b11, "outputs not released")
    sendWord(21'h0c0c0c, 10);
    cyc(80);
    `CHECK_EQ(recoveredClockOut, 1'b0, "clock output not low")
    `CHECK_EQ(parDataOut, last, "word not held")
    $display("test tx powerdown done");
  endtask

  // A word offered inside the lock interval must not reach the wire.
  task automatic t_lock;
    logic sawClk;
    sawClk = 1'b0;
    @(posedge clk_sys);
    txPowerdownN <= 1'b1;
    fork
      sendWord(21'h0f0f0f, 1);
      repeat (40) @(posedge clk_sys) if (forwardedClockOut === 1'b1) sawClk = 1'b1;
    join
    `CHECK_EQ(sawClk, 1'b0, "frame before lock")
    sendWord(21'h0a5a5a, 10);
    cyc(30);
    `CHECK_EQ(parDataOut, 21'h0a5a5a, "word after lock")
    $display("test lock done");
  endtask

  task automatic t_rxpd;
    @(posedge clk_sys);
    rxPowerdownN <= 1'b0;
    cyc(4);
    `CHECK_EQ({parDataOut, recoveredClockOut}, 22'h000000, "outputs not low")
    sendWord(21'h1c3c3c, 10);
    cyc(30);
    `CHECK_EQ(parDataOut, 21'h000000, "word passed in powerdown")
    rxPowerdownN <= 1'b1;
    cyc(20);
    sendWord(21'h03c3c3, 10);
    cyc(30);
    `CHECK_EQ(parDataOut, 21'h03c3c3, "word after receiver wake")
    $display("test rx powerdown done");
  endtask

  // Source faster than a frame: the two-entry buffer fills and refuses.
  task automatic t_overflow;
    seen.delete();
    sawDrop = 1'b0;
    for (int i = 0; i < 8; i++) sendWord(21'(i + 5), 4);
    cyc(150);
    `CHECK_EQ(sawDrop, 1'b1, "no drop pulse")
    `CHECK_EQ(seen[0], 21'h000005, "first word lost")
    `CHECK_EQ(seen[1], 21'h000006, "buffered word lost")
    $display("test overflow done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence after a three-cycle reset and the lock interval.
  initial begin
    rstn = 1'b0;
    sourceClockIn = 1'b0;
    parDataIn = '0;
    txPowerdownN = 1'b1;
    rxPowerdownN = 1'b1;
    cutData = 1'b0;
    sawDrop = 1'b0;
    n_fail = 0;
    n_checks = 0;
    cyc(3);
    rstn <= 1'b1;
    cyc(30);
    t_wire();
    t_burst();
    t_failsafe();
    t_txpd();
    t_lock();
    t_rxpd();
    t_overflow();
    give_verdict();
  end

  // The tests need about 900 cycles; a hang is cut well beyond that.
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    $display("mismatch at %0t ns: watchdog expired", $time);
    give_verdict();
  end
endmodule
`default_nettype wire
